// ---- ccp_pkg.sv ----
/*
 * Shared constants and types for the configuration-control pin logic.
 * Assumes every file of the block imports this package.
 */
package ccp_pkg;

	localparam int MODE_W      = 4;
	localparam int PLL_W       = 8;
	localparam int FRAME_W     = 16;
	localparam int SYNC_W      = 7;
	localparam int IDX_RESTART = 0;
	localparam int IDX_RDCFG   = 1;
	localparam int IDX_INIT    = 2;
	localparam int IDX_MODE_LO = 3;
	localparam int IDX_MODE_HI = 6;

	// Every synchronised pin has a pull-up, so each one idles high.
	localparam logic [SYNC_W-1:0]  SYNC_RST   = 7'h7f;
	localparam logic [MODE_W-1:0]  MODE_RST   = 4'h0;
	localparam logic [FRAME_W-1:0] FRAME_ZERO = 16'h0000;
	localparam logic [FRAME_W-1:0] FRAME_STEP = 16'h0001;
	localparam logic [PLL_W-1:0]   PLL_HIZ    = 8'h00;

	typedef enum logic [1:0] {
		CCP_CLEAR,
		CCP_WAIT,
		CCP_CONFIG,
		CCP_USER
	} ccp_state_t;

endpackage

// ---- ccp_pin_if.sv ----
/*
 * Bundle between the pin synchroniser and the control logic.
 * Assumes raw pins are asynchronous to ref_clk.
 */
`timescale 1ns/100ps
interface ccp_pin_if;
	import ccp_pkg::*;

	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] clean;

	modport sync (input raw, output clean);
	modport ctrl (output raw, input clean);
endinterface

// ---- ccp_pin_sync.sv ----
/*
 * Three-stage synchroniser for the asynchronous control pins.
 * Assumes ref_clk and an asynchronous active-low rstn.
 */
`timescale 1ns/100ps
module ccp_pin_sync (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Pins
	ccp_pin_if.sync   pins
);
	import ccp_pkg::*;

	wire [SYNC_W-1:0] clean_bits;

	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			// Each bit owns its flops, so no register is written by more than one process.
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic clean_reg;
			wire  agree;

			assign agree         = s2_reg == s3_reg;
			assign clean_bits[i] = clean_reg;
			// A new level is taken only once the last two stages agree, which filters a one-cycle glitch.
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					s1_reg    <= SYNC_RST[i];
					s2_reg    <= SYNC_RST[i];
					s3_reg    <= SYNC_RST[i];
					clean_reg <= SYNC_RST[i];
				end else begin
					s1_reg <= pins.raw[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (agree) begin
						clean_reg <= s3_reg;
					end
				end
			end
		end
	endgenerate

	assign pins.clean = clean_bits;
endmodule

// ---- ccp_config_ctrl.sv ----
/*
 * Configuration-control pin logic: restart, init handshake, mode capture,
 * global tristate, readback start, error or interrupt pin and PLL pin release.
 * Assumes ref_clk at 25 MHz; pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/100ps
module ccp_config_ctrl (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rstn,
	// Configuration pins
	input  wire logic                        config_restart_n,
	input  wire logic                        rd_cfg_n,
	input  wire logic                        init_in,
	output wire logic                        init_out,
	output wire logic                        init_oe,
	input  wire logic [ccp_pkg::MODE_W-1:0]  mode_pins,
	// Core status and options
	input  wire logic                        mem_clear_done,
	input  wire logic                        cfg_done,
	input  wire logic                        readback_opt,
	input  wire logic                        init_failed,
	input  wire logic                        host_processor_port,
	input  wire logic                        host_irq_req,
	// Readback and boundary-scan
	input  wire logic                        bscan_active,
	input  wire logic                        tdo_bit,
	input  wire logic                        readback_bit,
	input  wire logic                        frame_advance,
	input  wire logic                        readback_end,
	output wire logic                        readback_start,
	output wire logic                        readback_busy,
	output wire logic [ccp_pkg::FRAME_W-1:0] frame_addr,
	output wire logic                        rd_data_tdo,
	// Control outputs and the PLL usage input
	output wire logic                        bscan_reset,
	output wire logic                        config_abort,
	output wire logic                        global_io_tristate,
	output wire logic                        cfg_err_host_irq_n,
	output wire logic [ccp_pkg::MODE_W-1:0]  config_mode,
	output wire logic                        config_mode_valid,
	output wire logic                        configuring,
	input  wire logic [ccp_pkg::PLL_W-1:0]   pll_used,
	output wire logic [ccp_pkg::PLL_W-1:0]   pll_clock_inputs_user_en
);
	import ccp_pkg::*;

	ccp_pin_if pin_bus ();

	ccp_pin_sync u_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pins    (pin_bus.sync)
	);

	assign pin_bus.raw = {mode_pins, init_in, rd_cfg_n, config_restart_n};

	ccp_state_t         state_reg;
	ccp_state_t         state_next;
	logic               init_prev_reg;
	logic               rdcfg_prev_reg;
	logic [MODE_W-1:0]  mode_reg;
	logic               mode_valid_reg;
	logic               rb_active_reg;
	logic [FRAME_W-1:0] frame_reg;
	logic               ts_reg;
	logic               err_n_reg;
	logic               rd_data_reg;
	logic               bscan_reset_reg;
	logic               init_oe_reg;
	logic [PLL_W-1:0]   pll_en_reg;

	wire               restart_req;
	wire               rdcfg_lvl;
	wire               init_lvl;
	wire [MODE_W-1:0]  mode_lvl;
	wire               init_rise;
	wire               rdcfg_fall;
	wire               in_config;
	wire               mode_capture;
	wire               rb_start;
	wire               ts_next;
	wire               err_n_next;

	assign restart_req  = ~pin_bus.clean[IDX_RESTART];
	assign rdcfg_lvl    = pin_bus.clean[IDX_RDCFG];
	assign init_lvl     = pin_bus.clean[IDX_INIT];
	assign mode_lvl     = pin_bus.clean[IDX_MODE_HI:IDX_MODE_LO];
	assign init_rise    = init_lvl & ~init_prev_reg;
	assign rdcfg_fall   = rdcfg_prev_reg & ~rdcfg_lvl;
	assign in_config    = state_reg != CCP_USER;
	assign mode_capture = (state_reg == CCP_WAIT) & init_rise & ~restart_req;
	// The host holds the pin high through init, so no false edge is seen there.
	assign rb_start     = (state_reg == CCP_USER) & readback_opt & rdcfg_fall & ~rb_active_reg
	                      & ~restart_req;
	assign ts_next      = in_config ? ~rdcfg_lvl : (~readback_opt & ~rdcfg_lvl);
	assign err_n_next   = host_processor_port ? ~host_irq_req : ~(in_config & init_failed);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CCP_CLEAR: begin
				if (mem_clear_done) begin
					state_next = CCP_WAIT;
				end
			end
			CCP_WAIT: begin
				if (init_rise) begin
					state_next = CCP_CONFIG;
				end
			end
			CCP_CONFIG: begin
				if (cfg_done) begin
					state_next = CCP_USER;
				end
			end
			CCP_USER: state_next = CCP_USER;
			default:  state_next = CCP_CLEAR;
		endcase
		if (restart_req) begin
			state_next = CCP_CLEAR;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg      <= CCP_CLEAR;
			init_prev_reg  <= SYNC_RST[IDX_INIT];
			rdcfg_prev_reg <= SYNC_RST[IDX_RDCFG];
		end else begin
			state_reg      <= state_next;
			init_prev_reg  <= init_lvl;
			rdcfg_prev_reg <= rdcfg_lvl;
		end
	end

	// The mode is kept across later pin activity; only a new handshake edge replaces it.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg       <= MODE_RST;
			mode_valid_reg <= 1'b0;
		end else if (mode_capture) begin
			mode_reg       <= mode_lvl;
			mode_valid_reg <= 1'b1;
		end else if (restart_req) begin
			mode_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rb_active_reg <= 1'b0;
			frame_reg     <= FRAME_ZERO;
		end else if (restart_req) begin
			rb_active_reg <= 1'b0;
		end else if (rb_start) begin
			rb_active_reg <= 1'b1;
			frame_reg     <= FRAME_ZERO;
		end else if (rb_active_reg) begin
			rb_active_reg <= ~readback_end;
			frame_reg     <= frame_advance ? frame_reg + FRAME_STEP : frame_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ts_reg          <= 1'b0;
			err_n_reg       <= 1'b1;
			rd_data_reg     <= 1'b0;
			bscan_reset_reg <= 1'b1;
			init_oe_reg     <= 1'b1;
			pll_en_reg      <= PLL_HIZ;
		end else begin
			ts_reg          <= ts_next;
			err_n_reg       <= err_n_next;
			rd_data_reg     <= bscan_active ? tdo_bit : readback_bit;
			bscan_reset_reg <= restart_req;
			init_oe_reg     <= state_next == CCP_CLEAR;
			pll_en_reg      <= (state_reg == CCP_USER) ? ~pll_used : PLL_HIZ;
		end
	end

	assign init_out                 = 1'b0;
	assign init_oe                  = init_oe_reg;
	assign readback_start           = rb_start;
	assign readback_busy            = rb_active_reg;
	assign frame_addr               = frame_reg;
	assign rd_data_tdo              = rd_data_reg;
	assign bscan_reset              = bscan_reset_reg;
	assign config_abort             = restart_req & (state_reg == CCP_CONFIG);
	assign global_io_tristate       = ts_reg;
	assign cfg_err_host_irq_n       = err_n_reg;
	assign config_mode              = mode_reg;
	assign config_mode_valid        = mode_valid_reg;
	assign configuring              = in_config;
	assign pll_clock_inputs_user_en = pll_en_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence seq_restart_taken;
		state_reg == CCP_CLEAR && bscan_reset;
	endsequence

	sequence seq_rb_begun;
		rb_active_reg && frame_reg == FRAME_ZERO;
	endsequence

	chk_restart_abandons: assert property (restart_req |=> seq_restart_taken)
		else $error("restart did not return to clear with scan reset");
	chk_ts_during_cfg: assert property (in_config && !rdcfg_lvl |=> global_io_tristate)
		else $error("tristate not asserted during configuration");
	chk_ts_user_opt: assert property (!in_config && readback_opt |=> !global_io_tristate)
		else $error("tristate active while pin is readback trigger");
	chk_rb_start_frame: assert property (rb_start |=> seq_rb_begun)
		else $error("readback did not begin at frame zero");
	chk_rd_data_sel: assert property (bscan_active |=> rd_data_tdo == $past(tdo_bit))
		else $error("test data not routed to readback pin");
	chk_err_pin_low: assert property (in_config && init_failed && !host_processor_port |=> !cfg_err_host_irq_n)
		else $error("error pin not low on init failure");
	chk_host_irq_pin: assert property (host_processor_port |=> cfg_err_host_irq_n == !$past(host_irq_req))
		else $error("host interrupt not on error pin");
	chk_mode_capture: assert property (mode_capture |=> config_mode == $past(mode_lvl) && config_mode_valid)
		else $error("mode not captured on init rise");
	chk_pll_hiz: assert property (in_config |=> pll_clock_inputs_user_en == PLL_HIZ)
		else $error("pll pins released during configuration");
	chk_wait_hold: assert property (state_reg == CCP_WAIT && !init_lvl && !restart_req |=> state_reg == CCP_WAIT)
		else $error("left wait state while init held low");
	chk_mode_stable: assert property ($changed(config_mode) |-> $past(mode_capture))
		else $error("captured mode changed without a new capture");
endmodule

// ---- ccp_host_model.sv ----
/*
 * External configuration controller model that drives the control pins.
 * Assumes the bench changes its requests just after the falling clock edge.
 */
`timescale 1ns/100ps
module ccp_host_model (
	// Requests from the bench
	input  wire logic                       ref_clk,
	input  wire logic                       restart_req,
	input  wire logic                       init_release,
	input  wire logic                       rd_low_req,
	input  wire logic [ccp_pkg::MODE_W-1:0] mode_req,
	// Pins
	input  wire logic                       init_oe,
	output wire logic                       config_restart_n,
	output wire logic                       rd_cfg_n,
	output wire logic                       init_in,
	output wire logic [ccp_pkg::MODE_W-1:0] mode_pins
);
	logic init_seen_reg;

	initial init_seen_reg = 1'b0;
	// The init line is open drain with a pull-up, so either party can hold it low.
	assign init_in = init_release & ~init_oe;
	assign config_restart_n = ~restart_req;
	assign mode_pins = mode_req;
	// A low request is held back until init has been seen high.
	assign rd_cfg_n = ~(rd_low_req & init_seen_reg);
	always @(negedge ref_clk) begin
		if (restart_req)
			init_seen_reg <= 1'b0;
		else if (init_in)
			init_seen_reg <= 1'b1;
	end
endmodule

// ---- config_control_pin_logic_test.sv ----
/*
 * Self-checking bench for the configuration-control pin logic.
 * Assumes the host model on the pin side and core inputs driven here.
 */
`timescale 1ns/100ps
module config_control_pin_logic_test;
	logic        ref_clk = 1'b0, rstn = 1'b0;
	logic        restart_req = 1'b0, init_release = 1'b0, rd_low_req = 1'b0;
	logic [3:0]  mode_req = 4'h0;
	logic        mem_clear_done = 1'b0, cfg_done = 1'b0, readback_opt = 1'b0, init_failed = 1'b0;
	logic        host_processor_port = 1'b0, host_irq_req = 1'b0, bscan_active = 1'b0;
	logic        tdo_bit = 1'b0, readback_bit = 1'b0, frame_advance = 1'b0, readback_end = 1'b0;
	logic [7:0]  pll_used = 8'h0f;
	wire         config_restart_n, rd_cfg_n, init_in, init_out, init_oe, readback_start, readback_busy;
	wire  [3:0]  mode_pins, config_mode;
	wire  [15:0] frame_addr;
	wire         rd_data_tdo, bscan_reset, config_abort, global_io_tristate, cfg_err_host_irq_n;
	wire         config_mode_valid, configuring;
	wire  [7:0]  pll_en;
	int          fails = 0, tests_run = 0, cycles = 0;
	logic        seen;

	always #20 ref_clk = ~ref_clk;

	ccp_host_model host (.ref_clk(ref_clk), .restart_req(restart_req), .init_release(init_release),
		.rd_low_req(rd_low_req), .mode_req(mode_req), .init_oe(init_oe), .config_restart_n(config_restart_n),
		.rd_cfg_n(rd_cfg_n), .init_in(init_in), .mode_pins(mode_pins));

	ccp_config_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .config_restart_n(config_restart_n),
		.rd_cfg_n(rd_cfg_n), .init_in(init_in), .init_out(init_out), .init_oe(init_oe), .mode_pins(mode_pins),
		.mem_clear_done(mem_clear_done), .cfg_done(cfg_done), .readback_opt(readback_opt),
		.init_failed(init_failed), .host_processor_port(host_processor_port), .host_irq_req(host_irq_req),
		.bscan_active(bscan_active), .tdo_bit(tdo_bit), .readback_bit(readback_bit),
		.frame_advance(frame_advance), .readback_end(readback_end), .readback_start(readback_start),
		.readback_busy(readback_busy), .frame_addr(frame_addr), .rd_data_tdo(rd_data_tdo),
		.bscan_reset(bscan_reset), .config_abort(config_abort), .global_io_tristate(global_io_tristate),
		.cfg_err_host_irq_n(cfg_err_host_irq_n), .config_mode(config_mode),
		.config_mode_valid(config_mode_valid), .configuring(configuring), .pll_used(pll_used),
		.pll_clock_inputs_user_en(pll_en));

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic stop_test();
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Init is held low first, so configuration must wait; its release then captures the mode.
	task automatic test_config();
		mode_req = 4'ha;
		mem_clear_done = 1'b1;
		cyc(2);
		chk("init_oe", 16'h0, init_oe);
		cyc(12);
		chk("mode_valid", 16'h0, config_mode_valid);
		init_release = 1'b1;
		cyc(8);
		chk("mode_valid", 16'h1, config_mode_valid);
		chk("config_mode", 16'ha, config_mode);
		mode_req = 4'h5;
		cyc(8);
		chk("config_mode", 16'ha, config_mode);
		chk("pll_en", 16'h0, pll_en);
		rd_low_req = 1'b1;
		cyc(8);
		chk("tristate", 16'h1, global_io_tristate);
		rd_low_req = 1'b0;
		cyc(8);
		chk("tristate", 16'h0, global_io_tristate);
		init_failed = 1'b1;
		cyc(2);
		chk("err_n", 16'h0, cfg_err_host_irq_n);
		host_processor_port = 1'b1;
		cyc(2);
		chk("err_n", 16'h1, cfg_err_host_irq_n);
		host_irq_req = 1'b1;
		cyc(2);
		chk("err_n", 16'h0, cfg_err_host_irq_n);
		{init_failed, host_processor_port, host_irq_req} = 3'h0;
		cfg_done = 1'b1;
		cyc(3);
		chk("configuring", 16'h0, configuring);
		chk("pll_en", 16'hf0, pll_en);
	endtask

	task automatic test_readback();
		rd_low_req = 1'b1;
		cyc(8);
		chk("tristate", 16'h1, global_io_tristate);
		chk("busy", 16'h0, readback_busy);
		rd_low_req = 1'b0;
		readback_opt = 1'b1;
		cyc(8);
		rd_low_req = 1'b1;
		seen = 1'b0;
		for (int i = 0; i < 10 && seen !== 1'b1; i++) begin
			cyc(1);
			seen = readback_start;
		end
		chk("start", 16'h1, seen);
		cyc(1);
		chk("busy", 16'h1, readback_busy);
		chk("frame", 16'h0, frame_addr);
		repeat (2) begin
			frame_advance = 1'b1;
			cyc(1);
			frame_advance = 1'b0;
			cyc(1);
		end
		chk("frame", 16'h2, frame_addr);
		readback_end = 1'b1;
		cyc(1);
		readback_end = 1'b0;
		cyc(1);
		chk("busy", 16'h0, readback_busy);
		{readback_bit, tdo_bit} = 2'b10;
		cyc(2);
		chk("rd_data", 16'h1, rd_data_tdo);
		bscan_active = 1'b1;
		cyc(2);
		chk("rd_data", 16'h0, rd_data_tdo);
	endtask

	// Restart from user mode, then a fresh configuration captures the new mode.
	task automatic test_restart();
		cfg_done = 1'b0;
		rd_low_req = 1'b0;
		restart_req = 1'b1;
		cyc(6);
		chk("bscan_reset", 16'h1, bscan_reset);
		chk("configuring", 16'h1, configuring);
		chk("mode_valid", 16'h0, config_mode_valid);
		restart_req = 1'b0;
		cyc(12);
		chk("mode_valid", 16'h1, config_mode_valid);
		chk("config_mode", 16'h5, config_mode);
		chk("init_out", 16'h0, init_out);
		// Restart again while configuration is in progress, which must abort it.
		restart_req = 1'b1;
		seen = 1'b0;
		for (int i = 0; i < 10 && seen !== 1'b1; i++) begin
			cyc(1);
			seen = config_abort;
		end
		chk("abort", 16'h1, seen);
		cyc(1);
		chk("abort", 16'h0, config_abort);
		chk("mode_valid", 16'h0, config_mode_valid);
		chk("config_mode", 16'h5, config_mode);
		restart_req = 1'b0;
		cyc(2);
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			stop_test();
		end
	end

	initial begin
		cyc(2);
		chk("init_oe", 16'h1, init_oe);
		chk("bscan_reset", 16'h1, bscan_reset);
		chk("err_n", 16'h1, cfg_err_host_irq_n);
		rstn = 1'b1;
		test_config();
		test_readback();
		test_restart();
		stop_test();
	end
endmodule
